// >>> noise_bit_source.sv
// noise bit source with optional von neumann de-biasing
`timescale 1ns/1ns
`default_nettype none
module noise_bit_source #(
  parameter int BIT_CYC = 187
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic run,
  input  wire logic debias,
  output logic      bitValid,
  output logic      bitData
);

  logic [15:0] lfsr_r;       // stand-in noise stream
  logic [15:0] lfsr_nxt;
  logic [15:0] cnt_r;        // raw bit pacing
  logic [15:0] cnt_nxt;
  logic        half_r;       // first bit of a pair held
  logic        half_nxt;
  logic        first_r;      // first bit value
  logic        first_nxt;
  logic        vld_r;
  logic        vld_nxt;
  logic        dat_r;
  logic        dat_nxt;
  logic        raw;          // current raw bit
  logic        tick;         // raw bit ready

  assign raw  = lfsr_r[0];
  assign tick = (cnt_r == 16'(BIT_CYC - 1));
  assign bitValid = vld_r;
  assign bitData  = dat_r;

  // next-state: pace raw bits, pair them when de-biasing
  always_comb begin
    lfsr_nxt  = lfsr_r;
    cnt_nxt   = cnt_r;
    half_nxt  = half_r;
    first_nxt = first_r;
    vld_nxt   = 1'b0;
    dat_nxt   = dat_r;
    lfsr_nxt  = {lfsr_r[14:0],
                 lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    if (!run) begin
      cnt_nxt  = 16'h0000;
      half_nxt = 1'b0;
    end else if (tick) begin
      cnt_nxt = 16'h0000;
      if (!debias) begin
        vld_nxt = 1'b1;
        dat_nxt = raw;
      end else if (!half_r) begin
        half_nxt  = 1'b1;
        first_nxt = raw;
      end else begin
        // unequal pair yields first bit, equal pair dropped
        half_nxt = 1'b0;
        if (first_r != raw) begin
          vld_nxt = 1'b1;
          dat_nxt = first_r;
        end
      end
    end else begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  // registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lfsr_r  <= 16'hACE1;
      cnt_r   <= 16'h0000;
      half_r  <= 1'b0;
      first_r <= 1'b0;
      vld_r   <= 1'b0;
      dat_r   <= 1'b0;
    end else if (ce) begin
      lfsr_r  <= lfsr_nxt;
      cnt_r   <= cnt_nxt;
      half_r  <= half_nxt;
      first_r <= first_nxt;
      vld_r   <= vld_nxt;
      dat_r   <= dat_nxt;
    end
  end

endmodule
`default_nettype wire

// >>> testbench.sv
// register level testbench for the true random byte generator
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int START_CYC = 20; // shortened start-up delay
  localparam int BIT_CYC   = 2;  // shortened raw bit period
  logic        mclk, nrst, hsel, hwrite, irq, hreadyout, hresp, ce;
  logic [31:0] haddr, hwdata, hrdata, d, v;
  logic [1:0]  htrans;
  wire         hready;
  int          errors, nTests, cyc, i;
  logic [7:0]  b [4];   // debiased bytes
  logic [11:0] z [8] = '{trng_pkg::OFS_START, trng_pkg::OFS_STOP,
    trng_pkg::OFS_EVENT, trng_pkg::OFS_SHORT, trng_pkg::OFS_IENSET,
    trng_pkg::OFS_CONFIG, trng_pkg::OFS_VALUE, 12'h50C};
  assign hready = hreadyout; // single slave drives hready
  true_random_byte_generator #(.START_CYC(START_CYC), .BIT_CYC(BIT_CYC)) DUT (
    .mclk(mclk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq));
  // free running clock
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  // print counts and verdict, end run
  task automatic stopTest();
    $display("errors %0d compares %0d", errors, nTests);
    if (errors == 0 && nTests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // word compare
  task automatic check(input string n, input logic [31:0] e, g);
    nTests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // single ahb write: address phase, then data phase
  task automatic wr(input logic [11:0] a, input logic [31:0] x);
    hsel <= 1'h1; haddr <= {20'h0, a}; hwrite <= 1'h1;
    htrans <= trng_pkg::HTRANS_NONSEQ;
    do @(posedge mclk); while (hready !== 1'h1);
    htrans <= 2'h0; hwdata <= x;
    do @(posedge mclk); while (hready !== 1'h1);
  endtask
  // single ahb read, data taken at the closing edge
  task automatic rd(input logic [11:0] a, output logic [31:0] x);
    hsel <= 1'h1; haddr <= {20'h0, a}; hwrite <= 1'h0;
    htrans <= trng_pkg::HTRANS_NONSEQ;
    do @(posedge mclk); while (hready !== 1'h1);
    htrans <= 2'h0;
    do @(posedge mclk); while (hready !== 1'h1);
    x = hrdata;
  endtask
  // poll the flag under a bounded count
  task automatic waitFlag(input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      rd(trng_pkg::OFS_EVENT, d);
      if (d === 32'h1) break;
    end
    check("flag raised", 32'h1, d);
  endtask
  // timeout guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      stopTest();
    end
  end
  // main sequence
  initial begin
    nrst = 1'h0; hsel = 1'h0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'h0; hwdata = 32'h0; errors = 0; nTests = 0; ce = 1'h1;
    repeat (5) @(posedge mclk);
    nrst <= 1'h1;
    @(posedge mclk);
    foreach (z[j]) begin
      rd(z[j], d);
      check("reset value", 32'h0, d);
    end
    wr(trng_pkg::OFS_IENSET, 32'h1);
    rd(trng_pkg::OFS_IENCLR, d);
    check("irq enable", 32'h1, d);
    wr(trng_pkg::OFS_START, 32'h1);
    ce <= 1'h0; // frozen start-up delay must not advance
    repeat (100) @(posedge mclk);
    ce <= 1'h1;
    rd(trng_pkg::OFS_EVENT, d);
    check("flag in start delay", 32'h0, d);
    waitFlag(100);
    check("irq on flag", 32'h1, {31'h0, irq});
    rd(trng_pkg::OFS_VALUE, v);
    check("value top bits", 32'h0, v & 32'hFFFFFF00);
    wr(trng_pkg::OFS_EVENT, 32'h0);
    waitFlag(100);
    wr(trng_pkg::OFS_STOP, 32'h1);
    rd(trng_pkg::OFS_VALUE, v);
    wr(trng_pkg::OFS_EVENT, 32'h0);
    repeat (200) @(posedge mclk);
    rd(trng_pkg::OFS_EVENT, d);
    check("flag after stop", 32'h0, d);
    rd(trng_pkg::OFS_VALUE, d);
    check("value after stop", v, d);
    check("irq after clear", 32'h0, {31'h0, irq});
    wr(trng_pkg::OFS_SHORT, 32'h1);
    rd(trng_pkg::OFS_SHORT, d);
    check("shortcut", 32'h1, d);
    wr(trng_pkg::OFS_START, 32'h1);
    waitFlag(100);
    rd(trng_pkg::OFS_VALUE, v);
    wr(trng_pkg::OFS_EVENT, 32'h0);
    repeat (200) @(posedge mclk);
    rd(trng_pkg::OFS_EVENT, d);
    check("flag after auto stop", 32'h0, d);
    rd(trng_pkg::OFS_VALUE, d);
    check("value after auto stop", v, d);
    wr(trng_pkg::OFS_SHORT, 32'h0);
    wr(trng_pkg::OFS_CONFIG, 32'h1);
    rd(trng_pkg::OFS_CONFIG, d);
    check("debias setting", 32'h1, d);
    wr(trng_pkg::OFS_START, 32'h1);
    for (i = 0; i < 4; i++) begin
      waitFlag(600);
      rd(trng_pkg::OFS_VALUE, v);
      b[i] = v[7:0];
      wr(trng_pkg::OFS_EVENT, 32'h0);
    end
    d = {31'h0, !(b[0] == b[1] && b[1] == b[2] && b[2] == b[3])};
    check("debiased bytes vary", 32'h1, d);
    waitFlag(600);
    wr(trng_pkg::OFS_IENCLR, 32'h1);
    rd(trng_pkg::OFS_IENSET, d);
    check("enable after clear", 32'h0, d);
    check("irq after disable", 32'h0, {31'h0, irq});
    rd(trng_pkg::OFS_EVENT, d);
    check("flag kept", 32'h1, d);
    wr(trng_pkg::OFS_STOP, 32'h1);
    stopTest();
  end
endmodule
bind true_random_byte_generator trng_props #(
  .START_CYC(START_CYC), .BIT_CYC(BIT_CYC)) uProps (
  .mclk(mclk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .irq(irq));
`default_nettype wire

// >>> trng_pkg.sv
// package with register map, timing constants and carrier types for the trng
package trng_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_START  = 12'h000;
  localparam logic [11:0] OFS_STOP   = 12'h004;
  localparam logic [11:0] OFS_EVENT  = 12'h100;
  localparam logic [11:0] OFS_SHORT  = 12'h200;
  localparam logic [11:0] OFS_IENSET = 12'h304;
  localparam logic [11:0] OFS_IENCLR = 12'h308;
  localparam logic [11:0] OFS_CONFIG = 12'h504;
  localparam logic [11:0] OFS_VALUE  = 12'h508;

  // field positions and reset values
  localparam int          BIT_LSB      = 0;
  localparam logic [7:0]  VALUE_RST    = 8'h00;
  localparam logic [31:0] WORD_ZERO    = 32'h00000000;

  // clock rate and timing in their own units
  localparam int CLK_MHZ      = 50;
  localparam int START_US     = 128;
  localparam int RAW_BYTE_US  = 30;
  localparam int BC_BYTE_US   = 120;
  // derived cycle counts
  localparam int START_CYC    = START_US * CLK_MHZ;
  localparam int RAW_BYTE_CYC = RAW_BYTE_US * CLK_MHZ;
  // raw bit period: eight bits per raw byte
  localparam int RAW_BIT_CYC  = RAW_BYTE_CYC / 8;
  localparam int CNT_W        = 16;

  // ahb transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  // generator states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WARM  = 3'b010,
    ST_RUN   = 3'b100
  } gen_state_t;

  // captured ahb address phase
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
  } bus_req_t;

  // software-visible control bits
  typedef struct packed {
    logic debias;
    logic autoStop;
    logic irqEn;
  } ctrl_t;

endpackage

// >>> trng_props.sv
// checker for bus answers and interrupt behaviour of the trng
`timescale 1ns/1ns
`default_nettype none
module trng_props #(
  parameter int START_CYC = 20,
  parameter int BIT_CYC   = 2
) (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        irq
);
  trng_pkg::bus_req_t dph_r, dph_nxt; // transfer in data phase
  logic               en_r, en_nxt;   // irq enable shadow
  logic               rd, wr;         // data phase kind
  logic [11:0]        a;              // data phase offset
  assign rd = dph_r.valid & ~dph_r.write;
  assign wr = dph_r.valid & dph_r.write;
  assign a  = dph_r.addr;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // capture address phase, follow enable set and clear writes
  always_comb begin
    dph_nxt.valid = hsel & hready & htrans[1];
    dph_nxt.write = hwrite;
    dph_nxt.addr  = haddr[11:0];
    en_nxt = en_r;
    if (wr && a == trng_pkg::OFS_IENSET && hwdata[0]) en_nxt = 1'h1;
    if (wr && a == trng_pkg::OFS_IENCLR && hwdata[0]) en_nxt = 1'h0;
  end
  // register the tracking state
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dph_r <= '0;
      en_r  <= 1'h0;
    end else begin
      dph_r <= dph_nxt;
      en_r  <= en_nxt;
    end
  end
  property p_task_rd;
    rd && (a == trng_pkg::OFS_START || a == trng_pkg::OFS_STOP)
      |-> hrdata == 32'h0;
  endproperty
  a_task_rd: assert property (p_task_rd)
    else $error("task register read not zero");
  property p_flag_rd;
    rd && a == trng_pkg::OFS_EVENT |-> hrdata[31:1] == 31'h0;
  endproperty
  a_flag_rd: assert property (p_flag_rd)
    else $error("flag read has upper bits");
  property p_val_rd;
    rd && a == trng_pkg::OFS_VALUE |-> hrdata[31:8] == 24'h0;
  endproperty
  a_val_rd: assert property (p_val_rd)
    else $error("value read wider than a byte");
  property p_en_rd;
    rd && (a == trng_pkg::OFS_IENSET || a == trng_pkg::OFS_IENCLR)
      |-> hrdata == {31'h0, en_r};
  endproperty
  a_en_rd: assert property (p_en_rd)
    else $error("enable readback wrong");
  property p_idle_rd;
    !rd |-> hrdata == 32'h0;
  endproperty
  a_idle_rd: assert property (p_idle_rd)
    else $error("read data outside a read");
  property p_irq_en;
    irq |-> en_r;
  endproperty
  a_irq_en: assert property (p_irq_en)
    else $error("irq without enable");
  property p_irq_hold;
    irq && !(wr && (a == trng_pkg::OFS_EVENT || a == trng_pkg::OFS_IENCLR))
      |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped without clear");
  property p_clr_irq;
    wr && a == trng_pkg::OFS_IENCLR && hwdata[0] |=> !irq ##1 !irq;
  endproperty
  a_clr_irq: assert property (p_clr_irq)
    else $error("irq stays after enable clear");
  property p_bus_ok;
    hreadyout && !hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok)
    else $error("bus answer not ready or okay");
  c_irq: cover property ($rose(irq));
  c_val: cover property (rd && a == trng_pkg::OFS_VALUE);
  c_clr: cover property (wr && a == trng_pkg::OFS_IENCLR && hwdata[0]);
endmodule
`default_nettype wire

// >>> true_random_byte_generator.sv
// top of the true random byte generator with ahb-lite register slave
`timescale 1ns/1ns
`default_nettype none
module true_random_byte_generator #(
  parameter int START_CYC = trng_pkg::START_CYC,
  parameter int BIT_CYC   = trng_pkg::RAW_BIT_CYC
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq
);

  // operation in brief:
  // - a bus write of one to the start trigger leaves idle for the
  //   start-up delay, which runs once per start and never between bytes
  // - while running, bits from the noise source shift into the holding
  //   register; the eighth bit loads the output value in parallel
  // - each load sets the value-ready flag; nothing buffers older bytes,
  //   so software must fetch each value before the next one lands
  // - the shortcut bit turns every load into a stop as well, unless a start write lands in the same cycle
  // - a stop write drops straight back to idle, mid-byte or mid-delay
  // - the flag stays set until software writes it; a byte landing in
  //   the same cycle as that write keeps the flag set
  // - bus answers take no wait states: read data is registered at the
  //   address phase and stands for the single data-phase cycle

  // bus state
  trng_pkg::bus_req_t req_r;      // latched address phase
  trng_pkg::bus_req_t req_nxt;
  logic [31:0]        rdata_r;    // read data register
  logic [31:0]        rdata_nxt;

  // control and status
  trng_pkg::ctrl_t    ctrl_r;     // debias, shortcut, irq enable
  trng_pkg::ctrl_t    ctrl_nxt;
  logic               flag_r;     // value-ready flag
  logic               flag_nxt;
  logic [7:0]         value_r;    // output value
  logic [7:0]         value_nxt;
  logic               irq_r;
  logic               irq_nxt;
  logic               ready_r;    // registered ready answer
  logic               ready_nxt;
  logic               resp_r;     // registered response, always okay
  logic               resp_nxt;

  // generator
  trng_pkg::gen_state_t st_r;
  trng_pkg::gen_state_t st_nxt;
  logic [trng_pkg::CNT_W-1:0] warm_r;   // start-up delay counter
  logic [trng_pkg::CNT_W-1:0] warm_nxt;
  logic [7:0]         shift_r;    // holding shift register
  logic [7:0]         shift_nxt;
  logic [2:0]         nbit_r;     // bits collected
  logic [2:0]         nbit_nxt;

  // decoded bus strokes and generator status
  logic               wrStart;
  logic               wrStop;
  logic               wrFlag;
  logic               byteDone;   // full byte this cycle
  logic               srcValid;
  logic               srcBit;
  logic               running;

  // true when the latched write hits offset ofs with bit 0 set
  function automatic logic hitOne(input trng_pkg::bus_req_t r,
                                  input logic [11:0] ofs,
                                  input logic [31:0] d);
    hitOne = r.valid && r.write && (r.addr == ofs) && d[trng_pkg::BIT_LSB];
  endfunction

  assign hrdata    = rdata_r;
  assign hreadyout = ready_r;
  assign hresp     = resp_r;
  assign irq       = irq_r;

  assign running = (st_r == trng_pkg::ST_RUN);
  assign wrStart = hitOne(req_r, trng_pkg::OFS_START, hwdata);
  assign wrStop  = hitOne(req_r, trng_pkg::OFS_STOP, hwdata);
  assign wrFlag  = req_r.valid && req_r.write &&
                   (req_r.addr == trng_pkg::OFS_EVENT);
  assign byteDone = running && srcValid && (nbit_r == 3'd7);

  // bit source paced so raw bytes take about 30 us
  noise_bit_source #(
    .BIT_CYC (BIT_CYC)
  ) u_src (
    .mclk     (mclk),
    .nrst     (nrst),
    .ce       (ce),
    .run      (running),
    .debias   (ctrl_r.debias),
    .bitValid (srcValid),
    .bitData  (srcBit)
  );

  // generator sequencing: idle, start-up delay, running
  always_comb begin
    st_nxt    = st_r;
    warm_nxt  = warm_r;
    shift_nxt = shift_r;
    nbit_nxt  = nbit_r;
    value_nxt = value_r;
    case (st_r)
      trng_pkg::ST_IDLE: begin
        // no seed needed, just go
        if (wrStart) begin
          st_nxt   = trng_pkg::ST_WARM;
          warm_nxt = '0;
        end
      end
      trng_pkg::ST_WARM: begin
        // one-time delay, only after start
        if (warm_r == trng_pkg::CNT_W'(START_CYC - 1)) begin
          st_nxt   = trng_pkg::ST_RUN;
          nbit_nxt = 3'd0;
        end else begin
          warm_nxt = warm_r + trng_pkg::CNT_W'(1);
        end
      end
      trng_pkg::ST_RUN: begin
        if (srcValid) begin
          // shift in bits, byte whenever ready, no fixed latency
          shift_nxt = {shift_r[6:0], srcBit};
          nbit_nxt  = nbit_r + 3'd1;
        end
        if (byteDone) begin
          // parallel load; overwrites the previous byte
          value_nxt = {shift_r[6:0], srcBit};
          if (ctrl_r.autoStop) begin
            st_nxt = trng_pkg::ST_IDLE;
          end
        end
      end
      default: st_nxt = trng_pkg::ST_IDLE;
    endcase
    if (wrStop) begin
      st_nxt = trng_pkg::ST_IDLE;
    end else if (wrStart && st_r != trng_pkg::ST_IDLE) begin
      st_nxt = st_r;                // already started: no restart delay
    end
  end

  // generator registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r    <= trng_pkg::ST_IDLE;
      warm_r  <= '0;
      shift_r <= trng_pkg::VALUE_RST;
      nbit_r  <= 3'd0;
      value_r <= trng_pkg::VALUE_RST;
    end else if (ce) begin
      st_r    <= st_nxt;
      warm_r  <= warm_nxt;
      shift_r <= shift_nxt;
      nbit_r  <= nbit_nxt;
      value_r <= value_nxt;
    end
  end

  // bus slave, control bits, event flag and interrupt
  always_comb begin
    req_nxt   = req_r;
    rdata_nxt = rdata_r;
    ctrl_nxt  = ctrl_r;
    flag_nxt  = flag_r;
    // zero wait states and always okay, held in flops
    ready_nxt = 1'b1;
    resp_nxt  = 1'b0;
    // address phase capture
    if (hready) begin
      req_nxt.valid = hsel && htrans[1];
      req_nxt.write = hwrite;
      req_nxt.addr  = haddr[11:0];
    end
    // data phase writes
    if (req_r.valid && req_r.write) begin
      if (req_r.addr == trng_pkg::OFS_SHORT) begin
        ctrl_nxt.autoStop = hwdata[trng_pkg::BIT_LSB];
      end else if (req_r.addr == trng_pkg::OFS_IENSET) begin
        if (hwdata[trng_pkg::BIT_LSB]) ctrl_nxt.irqEn = 1'b1;
      end else if (req_r.addr == trng_pkg::OFS_IENCLR) begin
        if (hwdata[trng_pkg::BIT_LSB]) ctrl_nxt.irqEn = 1'b0;
      end else if (req_r.addr == trng_pkg::OFS_CONFIG) begin
        ctrl_nxt.debias = hwdata[trng_pkg::BIT_LSB];
      end
    end
    // software write to flag, then hardware event wins
    if (wrFlag) begin
      flag_nxt = hwdata[trng_pkg::BIT_LSB];
    end
    if (byteDone) begin
      flag_nxt = 1'b1;   // one event per loaded byte
    end
    // read data for the next data phase
    rdata_nxt = trng_pkg::WORD_ZERO;
    if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr[11:0] == trng_pkg::OFS_EVENT) begin
        rdata_nxt = {31'h0, flag_nxt};
      end else if (haddr[11:0] == trng_pkg::OFS_SHORT) begin
        rdata_nxt = {31'h0, ctrl_nxt.autoStop};
      end else if (haddr[11:0] == trng_pkg::OFS_IENSET) begin
        rdata_nxt = {31'h0, ctrl_nxt.irqEn};
      end else if (haddr[11:0] == trng_pkg::OFS_IENCLR) begin
        rdata_nxt = {31'h0, ctrl_nxt.irqEn};
      end else if (haddr[11:0] == trng_pkg::OFS_CONFIG) begin
        rdata_nxt = {31'h0, ctrl_nxt.debias};
      end else if (haddr[11:0] == trng_pkg::OFS_VALUE) begin
        rdata_nxt = {24'h0, value_nxt};
      end else begin
        rdata_nxt = trng_pkg::WORD_ZERO;  // tasks and unmapped read zero
      end
    end
    // level interrupt from flag and enable
    irq_nxt = flag_nxt && ctrl_nxt.irqEn;
  end

  // bus and control registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      req_r   <= '0;
      ready_r <= 1'b1;
      resp_r  <= 1'b0;
      rdata_r <= trng_pkg::WORD_ZERO;
      ctrl_r  <= '0;
      flag_r  <= 1'b0;
      irq_r   <= 1'b0;
    end else if (ce) begin
      req_r   <= req_nxt;
      ready_r <= ready_nxt;
      resp_r  <= resp_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r  <= ctrl_nxt;
      flag_r  <= flag_nxt;
      irq_r   <= irq_nxt;
    end
  end

endmodule
`default_nettype wire
